// *** inc/swk_pkg.sv ***
// constants, types and decode helpers for the selective-wake mode and flag logic
// assumes one 125 MHz clock and an 8-bit register port with one-cycle read latency
// ==========================================================================
package swk_pkg;
  // ========================================================================
  // register map
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  localparam logic [1:0] ADDR_PROTOCOL_ERROR_COUNT = 2'h3;
  localparam int CTRL_CFG_VALID = 0;
  localparam int CTRL_TO_MASK = 1;
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_SILENCE = 1;
  localparam int STAT_SYNC = 2;
  localparam int STAT_ARMED = 3;
  localparam int STAT_ERROR = 4;
  localparam int STAT_WAKE = 5;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h3;
  localparam logic [2:0] MODE_WAKE = 3'h1;
  localparam logic [2:0] MODE_OFF_ALT = 3'h4;
  localparam logic [7:0] RDATA_ZERO = 8'h00;
  // ========================================================================
  // error counter and silence timer
  localparam logic [5:0] PROTOCOL_ERROR_COUNT_TOP = 6'h1F;
  localparam logic [5:0] PROTOCOL_ERROR_COUNT_OVER = 6'h20;
  localparam logic [5:0] PROTOCOL_ERROR_COUNT_ONE = 6'h01;
  localparam logic [5:0] PROTOCOL_ERROR_COUNT_ZERO = 6'h00;
  localparam int SILENCE_US = 1000;
  localparam int CLOCK_MHZ = 125;
  localparam int SILENCE_CYCLES = SILENCE_US * CLOCK_MHZ;
  localparam int TIMER_W = 20;
  localparam logic TX_RECESSIVE = 1'b1;
  // ========================================================================
  // types
  typedef enum logic [3:0] {
    SBC_NORMAL = 4'h1, SBC_STOP = 4'h2, SBC_SLEEP = 4'h4, SBC_RESTART = 4'h8
  } sbc_mode_e;
  typedef enum logic [4:0] {
    SW_IDLE = 5'h01, SW_FRAME = 5'h02, SW_PAT1 = 5'h04, SW_PAT2 = 5'h08, SW_WOKEN = 5'h10
  } sw_state_e;
  typedef enum logic [3:0] {
    OP_OFF = 4'h1, OP_WAKE = 4'h2, OP_RXONLY = 4'h4, OP_NORMAL = 4'h8
  } op_mode_e;

  // a selective-wake code: bit 2 set and not the second off code
  function automatic logic swk_code(input logic [2:0] f);
    return f[2] && (f[1:0] != 2'h0);
  endfunction

  // operation actually carried out for a stored code
  function automatic op_mode_e op_of(input logic [2:0] f, input sbc_mode_e sbc);
    case (f[1:0])
      2'h0: return OP_OFF;
      2'h1: return OP_WAKE;
      2'h2: return OP_RXONLY;
      default: return (sbc == SBC_STOP && !f[2]) ? OP_WAKE : OP_NORMAL;
    endcase
  endfunction
endpackage

// *** inc/swk_link_if.sv ***
// signals between the mode logic and its counter and silence timer
// assumes all three parties run on the one clock
`timescale 1ns/1ps
interface swk_link_if;
  logic inc;
  logic dec;
  logic clear;
  logic freeze;
  logic [5:0] count;
  logic overflow;
  logic restart;
  logic run;
  logic expire;
  modport ctl (output inc, dec, clear, freeze, restart, run, input count, overflow, expire);
  modport cnt (input inc, dec, clear, freeze, output count, overflow);
  modport tmr (input restart, run, output expire);
endinterface

// *** hdl/swk_error_counter.sv ***
// protocol error counter with overflow pulse at the step from 31 to 32
// assumes increment and decrement requests are already gated by the enable
`timescale 1ns/1ps
module swk_error_counter (
  input wire logic clock,
  input wire logic resetn,
  swk_link_if.cnt link
);
  import swk_pkg::*;
  logic [5:0] count_q, count_d;
  logic overflow_q, overflow_d;

  always_comb begin
    count_d = count_q;
    overflow_d = 1'b0;
    if (link.clear) begin
      count_d = PROTOCOL_ERROR_COUNT_ZERO;
    end else if (link.freeze) begin
      count_d = count_q;
    end else if (link.inc) begin
      count_d = count_q + PROTOCOL_ERROR_COUNT_ONE;
      overflow_d = (count_q == PROTOCOL_ERROR_COUNT_TOP);
    end else if (link.dec && count_q != PROTOCOL_ERROR_COUNT_ZERO) begin
      count_d = count_q - PROTOCOL_ERROR_COUNT_ONE;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= PROTOCOL_ERROR_COUNT_ZERO;
      overflow_q <= 1'b0;
    end else begin
      count_q <= count_d;
      overflow_q <= overflow_d;
    end
  end

  assign link.count = count_q;
  assign link.overflow = overflow_q;
endmodule // swk_error_counter

// *** hdl/swk_silence_timer.sv ***
// bus silence timer: one expiry pulse per quiet period
// assumes restart is high for any bus activity
`timescale 1ns/1ps
module swk_silence_timer #(
  parameter int CYCLES = swk_pkg::SILENCE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  swk_link_if.tmr link
);
  import swk_pkg::*;
  localparam logic [TIMER_W-1:0] TERMINAL = TIMER_W'(CYCLES - 1);
  logic [TIMER_W-1:0] count_q, count_d;
  logic expire_q, expire_d;

  // counter holds at terminal so expiry fires once until restart, by bus activity or a sub-state change
  always_comb begin
    count_d = count_q;
    expire_d = 1'b0;
    if (link.restart || !link.run) begin
      count_d = '0;
    end else if (count_q != TERMINAL) begin
      count_d = count_q + 1'b1;
      expire_d = (count_d == TERMINAL);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      expire_q <= 1'b0;
    end else begin
      count_q <= count_d;
      expire_q <= expire_d;
    end
  end

  assign link.expire = expire_q;
endmodule // swk_silence_timer

// *** hdl/swk_mode_flags.sv ***
// transceiver mode field, selective-wake sub-states and status flags
// assumes bus event inputs are one-cycle pulses from the frame decoder
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module swk_mode_flags #(
  parameter int SILENCE_CYCLES = swk_pkg::SILENCE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire swk_pkg::sbc_mode_e sbc_mode,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bus_activity,
  input wire logic frame_valid,
  input wire logic protocol_error,
  input wire logic wake_pattern,
  input wire logic wake_frame,
  input wire logic bus_rx,
  input wire logic tx_pin,
  output logic rx_pin,
  output logic bus_tx,
  output logic timeout_irq,
  output logic wake_irq,
  output logic wake_request
);
  import swk_pkg::*;

  // ========================================================================
  // state
  swk_link_if link ();
  sw_state_e state_q, state_d;
  logic [2:0] field_q, field_d;
  logic cfg_valid_q, cfg_valid_d;
  logic to_mask_q, to_mask_d;
  logic timeout_q, timeout_d;
  logic silence_q, silence_d;
  logic sync_q, sync_d;
  logic armed_q, armed_d;
  logic error_q, error_d;
  logic wake_q, wake_d;
  logic timeout_irq_q, timeout_irq_d;
  logic wake_irq_q, wake_irq_d;
  logic wake_req_q, wake_req_d;
  logic rx_q, rx_d;
  logic tx_q, tx_d;
  logic [7:0] rdata_q, rdata_d;

  op_mode_e op;
  logic sel;
  logic swk_live;
  logic mode_wr;
  logic stat_wr;
  logic ctrl_wr;
  logic det_state;
  logic wake_evt;
  logic cfg_error;
  logic sync_track;
  logic timeout_evt;

  swk_error_counter u_counter (
    .clock(clock),
    .resetn(resetn),
    .link(link)
  );

  swk_silence_timer #(
    .CYCLES(SILENCE_CYCLES)
  ) u_timer (
    .clock(clock),
    .resetn(resetn),
    .link(link)
  );

  // ========================================================================
  // decode
  always_comb begin
    sel = swk_code(field_q);
    op = op_of(field_q, sbc_mode);
    // the stored code is kept; the error flag only removes frame matching
    swk_live = sel && !error_q;
    mode_wr = reg_wr && reg_addr == ADDR_MODE && sbc_mode == SBC_NORMAL;
    ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;
    stat_wr = reg_wr && reg_addr == ADDR_STAT;
    det_state = state_q == SW_FRAME || state_q == SW_PAT2;
    timeout_evt = link.expire && det_state;
    wake_evt = (state_q == SW_FRAME && wake_frame && swk_live)
      || (state_q == SW_PAT2 && wake_pattern)
      || (state_q == SW_FRAME && link.overflow);
    // config check on enabling, or config dropped while enabled in Normal
    cfg_error = (mode_wr && swk_code(reg_wdata[2:0]) && !cfg_valid_q)
      || (ctrl_wr && sel && sbc_mode == SBC_NORMAL && !reg_wdata[CTRL_CFG_VALID]);
    sync_track = op == OP_NORMAL || op == OP_RXONLY || state_q == SW_FRAME;
  end

  // ========================================================================
  // selective-wake sub-state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      SW_IDLE: begin
        // entry does not look at sync, so a silent bus never blocks it
        if (sel) begin
          state_d = error_q ? SW_PAT2 : SW_FRAME;
        end
      end
      SW_FRAME: begin
        if (wake_evt) begin
          state_d = SW_WOKEN;
        end else if (error_q) begin
          state_d = SW_PAT2;
        end else if (link.expire) begin
          state_d = SW_PAT1;
        end
      end
      SW_PAT1: begin
        if (error_q) begin
          state_d = SW_PAT2;
        end else if (wake_pattern) begin
          state_d = SW_FRAME;
        end
      end
      SW_PAT2: begin
        if (wake_pattern) begin
          state_d = SW_WOKEN;
        end
      end
      SW_WOKEN: begin
        state_d = SW_WOKEN;
      end
      default: begin
        state_d = SW_IDLE;
      end
    endcase
    // rewriting the field rearms; clearing bit 2 leaves selective wake
    if (mode_wr || !sel) begin
      state_d = SW_IDLE;
    end
  end

  // ========================================================================
  // counter and timer control
  always_comb begin
    link.inc = protocol_error && sync_track;
    link.dec = frame_valid && sync_track;
    link.freeze = state_q == SW_WOKEN;
    link.clear = (state_q == SW_FRAME && state_d == SW_PAT1)
      || (state_d == SW_FRAME && state_q != SW_FRAME)
      || mode_wr
      || field_q == MODE_RESET || field_q == MODE_OFF_ALT || field_q == MODE_WAKE;
    link.restart = bus_activity || state_d != state_q;
    link.run = det_state || state_q == SW_PAT1;
  end

  // ========================================================================
  // registers and flags
  always_comb begin
    field_d = field_q;
    cfg_valid_d = cfg_valid_q;
    to_mask_d = to_mask_q;
    timeout_d = timeout_q;
    silence_d = silence_q;
    sync_d = sync_q;
    armed_d = armed_q;
    error_d = error_q;
    wake_d = wake_q;
    if (mode_wr) begin
      field_d = reg_wdata[2:0];
    end
    if (ctrl_wr) begin
      cfg_valid_d = reg_wdata[CTRL_CFG_VALID];
      to_mask_d = reg_wdata[CTRL_TO_MASK];
    end
    if (wake_evt && state_q == SW_FRAME) begin
      cfg_valid_d = 1'b0;
    end
    // software clears by writing one; a same-cycle hardware set wins
    if (stat_wr && reg_wdata[STAT_TIMEOUT]) begin
      timeout_d = 1'b0;
    end
    if (timeout_evt) begin
      timeout_d = 1'b1;
    end
    if (wake_pattern) begin
      silence_d = 1'b0;
    end
    if (timeout_evt) begin
      silence_d = 1'b1;
    end
    if (sync_track && frame_valid) begin
      sync_d = 1'b1;
    end
    if (sync_track && protocol_error) begin
      sync_d = 1'b0;
    end
    if (state_q == SW_PAT2 || ((state_q == SW_FRAME || state_q == SW_PAT1) && !error_q)) begin
      armed_d = 1'b1;
    end
    if (wake_evt || !field_q[2]) begin
      armed_d = 1'b0;
    end
    // clearing is refused while selective wake lacks a valid configuration
    if (stat_wr && reg_wdata[STAT_ERROR] && !(field_q[2] && !cfg_valid_q)) begin
      error_d = 1'b0;
    end
    if (mode_wr && swk_code(reg_wdata[2:0]) && cfg_valid_q) begin
      error_d = 1'b0;
    end
    if ((sel && link.overflow) || cfg_error) begin
      error_d = 1'b1;
    end
    if (stat_wr && reg_wdata[STAT_WAKE]) begin
      wake_d = 1'b0;
    end
    if (wake_evt) begin
      wake_d = 1'b1;
    end
  end

  // ========================================================================
  // pins, pulses and read port
  always_comb begin
    // timeout fires again even while the flag is still set
    timeout_irq_d = timeout_evt && to_mask_q
      && (sbc_mode == SBC_NORMAL || sbc_mode == SBC_STOP);
    // a wake frame in Normal interrupts but leaves the receive pin alone
    wake_irq_d = wake_evt && (sbc_mode == SBC_NORMAL || sbc_mode == SBC_STOP);
    wake_req_d = wake_evt;
    rx_d = (op == OP_NORMAL || op == OP_RXONLY) ? bus_rx : TX_RECESSIVE;
    tx_d = (op == OP_NORMAL) ? tx_pin : TX_RECESSIVE;
    rdata_d = RDATA_ZERO;
    if (reg_rd) begin
      if (reg_addr == ADDR_MODE) begin
        rdata_d = {5'h00, field_q};
      end else if (reg_addr == ADDR_CTRL) begin
        rdata_d = {6'h00, to_mask_q, cfg_valid_q};
      end else if (reg_addr == ADDR_STAT) begin
        rdata_d = {2'h0, wake_q, error_q, armed_q, sync_q, silence_q, timeout_q};
      end else begin
        rdata_d = {2'h0, link.count};
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= SW_IDLE;
      field_q <= MODE_RESET;
      cfg_valid_q <= 1'b0;
      to_mask_q <= 1'b0;
      timeout_q <= 1'b0;
      silence_q <= 1'b0;
      sync_q <= 1'b0;
      armed_q <= 1'b0;
      error_q <= 1'b0;
      wake_q <= 1'b0;
      timeout_irq_q <= 1'b0;
      wake_irq_q <= 1'b0;
      wake_req_q <= 1'b0;
      rx_q <= TX_RECESSIVE;
      tx_q <= TX_RECESSIVE;
      rdata_q <= RDATA_ZERO;
    end else begin
      state_q <= state_d;
      field_q <= field_d;
      cfg_valid_q <= cfg_valid_d;
      to_mask_q <= to_mask_d;
      timeout_q <= timeout_d;
      silence_q <= silence_d;
      sync_q <= sync_d;
      armed_q <= armed_d;
      error_q <= error_d;
      wake_q <= wake_d;
      timeout_irq_q <= timeout_irq_d;
      wake_irq_q <= wake_irq_d;
      wake_req_q <= wake_req_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign rx_pin = rx_q;
  assign bus_tx = tx_q;
  assign timeout_irq = timeout_irq_q;
  assign wake_irq = wake_irq_q;
  assign wake_request = wake_req_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence at_top_s;
    link.count == PROTOCOL_ERROR_COUNT_TOP && link.inc && !link.clear && !link.freeze && sel
      && state_q == SW_FRAME;
  endsequence
  sequence overflowed_s;
    link.count == PROTOCOL_ERROR_COUNT_OVER ##1 error_q && wake_req_q && state_q == SW_WOKEN;
  endsequence

  timeout_flag_set_a: assert property (timeout_evt |=> timeout_q)
    else $error("timeout flag not set on silence expiry");
  timeout_irq_a: assert property (
    timeout_evt && to_mask_q && (sbc_mode == SBC_NORMAL || sbc_mode == SBC_STOP)
    |=> timeout_irq && timeout_q)
    else $error("timeout interrupt missing");
  no_timeout_wake_a: assert property (timeout_evt && !wake_evt |=> !wake_request)
    else $error("timeout caused a wake");
  silence_clear_a: assert property (wake_pattern && !timeout_evt |=> !silence_q)
    else $error("silence flag kept after wake pattern");
  sync_set_a: assert property (
    sync_track && frame_valid && !protocol_error |=> sync_q)
    else $error("sync flag not set on valid frame");
  mode_lock_a: assert property (
    reg_wr && reg_addr == ADDR_MODE && sbc_mode != SBC_NORMAL |=> field_q == $past(field_q))
    else $error("mode field changed outside Normal");
  tx_block_a: assert property (op != OP_NORMAL |=> bus_tx == TX_RECESSIVE)
    else $error("transmit outside normal operation");
  armed_clear_a: assert property (!field_q[2] |=> !armed_q)
    else $error("armed flag kept with bit 2 low");
  overflow_wake_a: assert property (at_top_s |=> overflowed_s)
    else $error("counter overflow did not wake with error");
  stop_field_a: assert property (
    sbc_mode == SBC_STOP && field_q == MODE_NORMAL |-> op == OP_WAKE ##1 field_q == MODE_NORMAL)
    else $error("stop entry altered normal code handling");
  armed_set_a: assert property (
    state_q == SW_FRAME && !error_q && field_q[2] && !wake_evt |=> armed_q)
    else $error("armed flag not set in frame detection");
  error_set_a: assert property ((sel && link.overflow) || cfg_error |=> error_q)
    else $error("error flag not set on config error or overflow");
  wake_irq_a: assert property (
    wake_evt && sbc_mode == SBC_NORMAL |=> wake_irq && wake_request)
    else $error("wake frame in Normal gave no wake interrupt");
  frame_block_a: assert property (
    error_q && wake_frame && !wake_pattern && !link.overflow |=> !wake_request)
    else $error("wake frame accepted while error flag set");
  rx_follow_a: assert property (op == OP_NORMAL |=> rx_pin == $past(bus_rx))
    else $error("receive pin does not follow the bus");
endmodule // swk_mode_flags

// *** sim/can_bus_node.sv ***
// far-side bus node: frame decoder events and the wired receive level
// assumes the block's one clock; every event is a single-cycle pulse
`timescale 1ns/1ps
module can_bus_node (
  input wire logic clock,
  input wire logic bus_tx,
  output logic bus_activity,
  output logic frame_valid,
  output logic protocol_error,
  output logic wake_pattern,
  output logic wake_frame,
  output logic bus_rx
);
  logic [4:0] ev_q = 5'h00;
  logic level_q = 1'b1;
  // ==========================================================================
  // wired-and bus: a dominant level from either side wins
  assign bus_rx = bus_tx & level_q;
  assign {wake_frame, wake_pattern, protocol_error, frame_valid} = ev_q[3:0];
  assign bus_activity = ev_q[4];
  // any event is bus traffic, so it also restarts the silence timer
  task automatic send(input logic [3:0] ev);
    @(posedge clock);
    ev_q <= {1'b1, ev};
    @(posedge clock);
    ev_q <= 5'h00;
  endtask
  task automatic drive(input logic lvl);
    @(posedge clock);
    level_q <= lvl;
  endtask
endmodule // can_bus_node

// *** sim/tb_top.sv ***
// self-checking bench for the selective-wake mode and flag block
// assumes swk_pkg, the design files and the bus node model are compiled first
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import swk_pkg::*;
  // long enough that register traffic never trips the timer by accident
  localparam int SIL = 200;
  logic clock;
  logic resetn;
  sbc_mode_e sbc_mode;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic tx_pin;
  logic [7:0] reg_rdata, d;
  logic bus_activity, frame_valid, protocol_error, wake_pattern, wake_frame, bus_rx;
  logic rx_pin, bus_tx, timeout_irq, wake_irq, wake_request;
  int err_total = 0;
  int checked = 0;
  int n_to = 0, n_wi = 0, n_wr = 0, cyc = 0, n, k;
  // ==========================================================================
  // instances
  swk_mode_flags #(.SILENCE_CYCLES(SIL)) uut (.clock(clock), .resetn(resetn),
    .sbc_mode(sbc_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_activity(bus_activity),
    .frame_valid(frame_valid), .protocol_error(protocol_error), .wake_pattern(wake_pattern),
    .wake_frame(wake_frame), .bus_rx(bus_rx), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .bus_tx(bus_tx), .timeout_irq(timeout_irq), .wake_irq(wake_irq),
    .wake_request(wake_request));
  can_bus_node node (.clock(clock), .bus_tx(bus_tx), .bus_activity(bus_activity),
    .frame_valid(frame_valid), .protocol_error(protocol_error), .wake_pattern(wake_pattern),
    .wake_frame(wake_frame), .bus_rx(bus_rx));
  // ==========================================================================
  // clock, pulse counters and hang guard
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(negedge clock) begin
    n_to += int'(timeout_irq === 1'b1);
    n_wi += int'(wake_irq === 1'b1);
    n_wr += int'(wake_request === 1'b1);
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================================
  // access tasks
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic arm(input logic [7:0] code);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_MODE, code);
    tick(4);
  endtask
  task automatic mode_to(input sbc_mode_e m);
    @(posedge clock);
    sbc_mode <= m;
    tick(3);
    #1;
  endtask
  // counts edges until the next timeout pulse, bounded
  task automatic wait_to();
    n = n_to;
    for (k = 0; k < SIL + 40 && n_to == n; k++) @(posedge clock);
  endtask
  // ==========================================================================
  // tests
  initial begin
    resetn = 1'b0;
    sbc_mode = SBC_NORMAL;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_pin = 1'b1;
    tick(12);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a));
      `CHECK("reset reg", 8'h00, d)
    end
    `CHECK("reset bus_tx", 1'b1, bus_tx)
    $display("test reset done");
    node.drive(1'b0);
    tx_pin <= 1'b0;
    // all codes with config unset: selective codes also take a config error
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_MODE, 8'(c));
      tick(3);
      #1;
      `CHECK("rx_pin", c[1] ? 1'b0 : 1'b1, rx_pin)
      `CHECK("bus_tx", (c % 4 == 3) ? 1'b0 : 1'b1, bus_tx)
    end
    rd(ADDR_STAT);
    `CHECK("config error", 1'b1, d[STAT_ERROR])
    n = n_wr;
    node.send(4'h8);
    tick(2);
    `CHECK("blocked wake", n, n_wr)
    mode_to(SBC_STOP);
    `CHECK("stop 111 err tx", 1'b0, bus_tx)
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_MODE);
    `CHECK("stop field", 3'h7, d[2:0])
    mode_to(SBC_NORMAL);
    wr(ADDR_MODE, 8'h03);
    mode_to(SBC_STOP);
    `CHECK("stop 011 tx", 1'b1, bus_tx)
    `CHECK("stop 011 rx", 1'b1, rx_pin)
    rd(ADDR_MODE);
    `CHECK("stop 011 field", 3'h3, d[2:0])
    mode_to(SBC_NORMAL);
    node.drive(1'b1);
    tx_pin <= 1'b1;
    $display("test modes done");
    node.send(4'h1);
    rd(ADDR_STAT);
    `CHECK("sync set", 1'b1, d[STAT_SYNC])
    node.send(4'h2);
    rd(ADDR_STAT);
    `CHECK("sync clear", 1'b0, d[STAT_SYNC])
    wr(ADDR_STAT, 8'h31);
    arm(8'h07);
    rd(ADDR_STAT);
    `CHECK("armed", 1'b1, d[STAT_ARMED])
    `CHECK("error low", 1'b0, d[STAT_ERROR])
    mode_to(SBC_STOP);
    rd(ADDR_STAT);
    `CHECK("stop no sync armed", 2'h2, {d[STAT_ARMED], d[STAT_SYNC]})
    mode_to(SBC_NORMAL);
    n = n_wr;
    k = n_wi;
    node.send(4'h8);
    #1;
    `CHECK("rx during wake", 1'b1, rx_pin)
    tick(2);
    `CHECK("wake req", n + 1, n_wr)
    `CHECK("wake irq", k + 1, n_wi)
    rd(ADDR_STAT);
    `CHECK("wake flag armed", 2'h2, {d[STAT_WAKE], d[STAT_ARMED]})
    $display("test wake done");
    wr(ADDR_STAT, 8'h21);
    arm(8'h07);
    node.send(4'h0);
    wait_to();
    `CHECK("quiet min", 1'b1, k >= SIL - 1)
    `CHECK("quiet max", 1'b1, k <= SIL + 4)
    rd(ADDR_STAT);
    `CHECK("timeout silence", 2'h3, {d[STAT_SILENCE], d[STAT_TIMEOUT]})
    // second timeout in Stop, with the flag still set from the first
    wr(ADDR_MODE, 8'h07);
    mode_to(SBC_STOP);
    wait_to();
    `CHECK("second timeout", 1'b1, k < SIL + 40)
    mode_to(SBC_NORMAL);
    node.send(4'h4);
    rd(ADDR_STAT);
    `CHECK("silence cleared", 1'b0, d[STAT_SILENCE])
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_STAT, 8'h01);
    wr(ADDR_MODE, 8'h07);
    n = n_to;
    tick(SIL + 20);
    `CHECK("masked timeout", n, n_to)
    rd(ADDR_STAT);
    `CHECK("masked flag", 1'b1, d[STAT_TIMEOUT])
    arm(8'h07);
    mode_to(SBC_SLEEP);
    n = n_wr;
    tick(SIL + 20);
    `CHECK("sleep no wake", n, n_wr)
    mode_to(SBC_NORMAL);
    $display("test timeout done");
    wr(ADDR_MODE, 8'h07);
    tick(4);
    wr(ADDR_MODE, 8'h03);
    tick(2);
    rd(ADDR_STAT);
    `CHECK("bit2 clears armed", 1'b0, d[STAT_ARMED])
    arm(8'h07);
    repeat (31) node.send(4'h2);
    rd(ADDR_PROTOCOL_ERROR_COUNT);
    `CHECK("count 31", 6'h1F, d[5:0])
    n = n_wr;
    node.send(4'h2);
    // the wake pulse is counted on the falling edge after it rises
    tick(2);
    `CHECK("overflow wake", n + 1, n_wr)
    rd(ADDR_PROTOCOL_ERROR_COUNT);
    `CHECK("count 32", 6'h20, d[5:0])
    rd(ADDR_STAT);
    `CHECK("overflow flags", 2'h2, {d[STAT_ERROR], d[STAT_ARMED]})
    // the wake dropped the config, so the error flag may not be cleared
    wr(ADDR_STAT, 8'h10);
    rd(ADDR_STAT);
    `CHECK("error clear refused", 1'b1, d[STAT_ERROR])
    $display("test overflow done");
    results();
  end
endmodule // tb_top
